// ==== logic/bwc_defines.vh ====
// Offsets, field layouts and reset values for the bridge window register bank
`ifndef BWC_DEFINES_VH
`define BWC_DEFINES_VH

`define BWC_OFF_PF_TOP 8'h24
`define BWC_OFF_PF_BOT_HI 8'h28
`define BWC_OFF_PF_TOP_HI 8'h2c
`define BWC_OFF_IO_HI 8'h30
`define BWC_OFF_CAP 8'h34
`define BWC_OFF_IRQ 8'h3c

`define BWC_PF_TOP_MSB 31
`define BWC_PF_TOP_LSB 20
`define BWC_PF_TYPE_MSB 19
`define BWC_PF_TYPE_LSB 16
`define BWC_PF_TYPE_64 4'h1
`define BWC_PF_TOP_RST 12'h000
`define BWC_PF_LOW_ONES 20'hfffff
`define BWC_PF_LOW_ZERO 20'h00000

`define BWC_PF_HI_RST 32'h00000000
`define BWC_IO_HI_RST 16'h0000
`define BWC_IO_LOW_ONES 12'hfff
`define BWC_IO_LOW_ZERO 12'h000

`define BWC_CAP_PTR 8'h80
`define BWC_IRQ_LINE_RST 8'h00
`define BWC_IRQ_PIN 8'h00

`define BWC_RESP_OKAY 2'b00
`define BWC_RESP_SLVERR 2'b10

`endif

// ==== logic/bwc_window_cmp.v ====
// Inclusive address window comparator
module bwc_window_cmp #(
   parameter WIDTH = 32
) (
   input wire [WIDTH-1:0] addr,
   input wire [WIDTH-1:0] bottom,
   input wire [WIDTH-1:0] top,
   output wire hit
);

   // Both ends count as inside; bottom above top gives an empty window
   assign hit = (addr >= bottom) && (addr <= top);

endmodule // bwc_window_cmp

// ==== logic/bwc_regs.v ====
// Bridge forwarding window registers with AXI4-Lite access and window decode
//
// Contract
// - Prefetch limit bits 31:20 are writable and give top address bits 31:20.
// - Prefetch limit address bits 19:0 are taken as all ones.
// - Prefetch limit bits 19:16 read 0001, marking 64-bit support.
// - Prefetch bottom upper 32 bits: read-write, reset to zero.
// - Prefetch top upper 32 bits: read-write, reset to zero.
// - I/O bottom upper 16 bits in bits 15:0, read-write, reset zero.
// - I/O top upper 16 bits in bits 31:16, read-write, reset zero.
// - Capability pointer reads 80h always.
// - Interrupt line is plain storage; software should program FFh.
// - Interrupt pin field bits 15:8 reads zero.
// - 32-bit I/O bottom and top decide I/O forwarding.
// - 64-bit prefetch bottom and top decide memory forwarding.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`include "bwc_defines.vh"

module bwc_regs #(
   parameter ADDR_W = 8
) (
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // Lower window fields held by neighbouring registers
   input wire [11:0] pf_bottom_low,
   input wire [3:0] io_bottom_low,
   input wire [3:0] io_top_low,
   // Forwarding decode
   input wire [63:0] mem_addr,
   input wire [31:0] io_addr,
   output wire pf_hit,
   output wire io_hit,
   output wire [7:0] irq_line
);

   // Register state
   reg [11:0] pf_top_q;
   reg [31:0] pf_bot_hi_q;
   reg [31:0] pf_top_hi_q;
   reg [15:0] io_bot_hi_q;
   reg [15:0] io_top_hi_q;
   reg [7:0] irq_line_q;

   // Write channel state
   reg aw_held_q;
   reg [ADDR_W-1:0] aw_addr_q;
   reg w_held_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;

   // Read channel state
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;

   // Decode results
   reg pf_hit_q;
   reg io_hit_q;

   wire do_write;
   reg [7:0] wr_off;
   reg [7:0] rd_off;
   wire [31:0] bit_mask;
   wire pf_hit_raw;
   wire io_hit_raw;
   wire [63:0] pf_bottom;
   wire [63:0] pf_top;
   wire [31:0] io_bottom;
   wire [31:0] io_top;
   reg wr_mapped;
   reg rd_mapped;
   reg [31:0] rd_word;
   reg [31:0] wr_old;
   wire [31:0] wr_new;

   // Handshakes: one address and one data word held at a time
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   // Byte strobes widen to a bit mask, one lane per loop pass
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
         assign bit_mask[lane*8 +: 8] = {8{w_strb_q[lane]}};
      end
   endgenerate

   assign wr_new = (wr_old & ~bit_mask) | (w_data_q & bit_mask);

   // Current word image as software sees it
   function [31:0] reg_image;
      input [7:0] off;
      begin
         case (off)
            `BWC_OFF_PF_TOP: begin
               reg_image = {pf_top_q, `BWC_PF_TYPE_64, 16'h0000};
            end
            `BWC_OFF_PF_BOT_HI: begin
               reg_image = pf_bot_hi_q;
            end
            `BWC_OFF_PF_TOP_HI: begin
               reg_image = pf_top_hi_q;
            end
            `BWC_OFF_IO_HI: begin
               reg_image = {io_top_hi_q, io_bot_hi_q};
            end
            `BWC_OFF_CAP: begin
               reg_image = {24'h000000, `BWC_CAP_PTR};
            end
            `BWC_OFF_IRQ: begin
               // Upper half belongs to bridge control, outside this bank
               reg_image = {16'h0000, `BWC_IRQ_PIN, irq_line_q};
            end
            default: begin
               reg_image = 32'h00000000;
            end
         endcase
      end
   endfunction

   function is_mapped;
      input [7:0] off;
      begin
         case (off)
            `BWC_OFF_PF_TOP, `BWC_OFF_PF_BOT_HI, `BWC_OFF_PF_TOP_HI,
            `BWC_OFF_IO_HI, `BWC_OFF_CAP, `BWC_OFF_IRQ: begin
               is_mapped = 1'b1;
            end
            default: begin
               is_mapped = 1'b0;
            end
         endcase
      end
   endfunction

   // Word offsets; low address bits dropped, narrow buses zero-extended
   always @* begin
      wr_off = 8'h00;
      wr_off[ADDR_W-1:2] = aw_addr_q[ADDR_W-1:2];
      rd_off = 8'h00;
      rd_off[ADDR_W-1:2] = s_axi_araddr[ADDR_W-1:2];
      wr_old = reg_image(wr_off);
      wr_mapped = is_mapped(wr_off);
      rd_word = reg_image(rd_off);
      rd_mapped = is_mapped(rd_off);
   end

   // Write address and data capture, either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= {ADDR_W{1'b0}};
         w_held_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // Write response
   always @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `BWC_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_mapped ? `BWC_RESP_OKAY : `BWC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Register updates; read-only fields simply ignore the merge
   always @(posedge aclk) begin
      if (!aresetn) begin
         pf_top_q <= `BWC_PF_TOP_RST;
         pf_bot_hi_q <= `BWC_PF_HI_RST;
         pf_top_hi_q <= `BWC_PF_HI_RST;
         io_bot_hi_q <= `BWC_IO_HI_RST;
         io_top_hi_q <= `BWC_IO_HI_RST;
         irq_line_q <= `BWC_IRQ_LINE_RST;
      end else if (do_write) begin
         case (wr_off)
            `BWC_OFF_PF_TOP: begin
               pf_top_q <= wr_new[`BWC_PF_TOP_MSB:`BWC_PF_TOP_LSB];
            end
            `BWC_OFF_PF_BOT_HI: begin
               pf_bot_hi_q <= wr_new;
            end
            `BWC_OFF_PF_TOP_HI: begin
               pf_top_hi_q <= wr_new;
            end
            `BWC_OFF_IO_HI: begin
               io_bot_hi_q <= wr_new[15:0];
               io_top_hi_q <= wr_new[31:16];
            end
            `BWC_OFF_IRQ: begin
               // Storage only; nothing in the bridge acts on it beyond the read-back at 3Ch
               irq_line_q <= wr_new[7:0];
            end
            default: begin
               irq_line_q <= irq_line_q;
            end
         endcase
      end
   end

   // Read channel: one read in flight, data registered
   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `BWC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_mapped ? `BWC_RESP_OKAY : `BWC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Assembled windows; low bits implied so windows keep their granularity
   assign pf_bottom = {pf_bot_hi_q, pf_bottom_low, `BWC_PF_LOW_ZERO};
   assign pf_top = {pf_top_hi_q, pf_top_q, `BWC_PF_LOW_ONES};
   assign io_bottom = {io_bot_hi_q, io_bottom_low, `BWC_IO_LOW_ZERO};
   assign io_top = {io_top_hi_q, io_top_low, `BWC_IO_LOW_ONES};

   bwc_window_cmp #(
      .WIDTH(64)
   ) u_pf_cmp (
      .addr(mem_addr),
      .bottom(pf_bottom),
      .top(pf_top),
      .hit(pf_hit_raw)
   );

   bwc_window_cmp #(
      .WIDTH(32)
   ) u_io_cmp (
      .addr(io_addr),
      .bottom(io_bottom),
      .top(io_top),
      .hit(io_hit_raw)
   );

   // Registered so the 64-bit compare does not meet the caller's path
   always @(posedge aclk) begin
      if (!aresetn) begin
         pf_hit_q <= 1'b0;
         io_hit_q <= 1'b0;
      end else begin
         pf_hit_q <= pf_hit_raw;
         io_hit_q <= io_hit_raw;
      end
   end

   assign pf_hit = pf_hit_q;
   assign io_hit = io_hit_q;
   assign irq_line = irq_line_q;

endmodule // bwc_regs

// ==== test/bwc_regs_assertions.sv ====
// Concurrent checks on the window register bank ports
module bwc_chk (
   input logic aclk,
   input logic aresetn,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [7:0] s_axi_araddr,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0] s_axi_rresp,
   input logic s_axi_rvalid,
   input logic [7:0] irq_line,
   input logic pf_hit,
   input logic io_hit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ra_q;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Read offset kept so read data can be judged when it appears
   always @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ra_q <= s_axi_araddr;
      end
   end
   property p_busy_refuse;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("request taken while response pending");
   property p_ready_back;
      $fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready;
   endproperty
   a_ready_back: assert property (p_ready_back) else $error("ready not restored after response");
   property p_wr_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write response late");
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_cap;
      s_axi_rvalid && ra_q[7:2] == 6'h0d |-> s_axi_rdata == 32'h00000080;
   endproperty
   a_cap: assert property (p_cap) else $error("capability pointer wrong");
   property p_pf_type;
      s_axi_rvalid && ra_q[7:2] == 6'h09 |-> s_axi_rdata[19:16] == 4'h1;
   endproperty
   a_pf_type: assert property (p_pf_type) else $error("addressing type wrong");
   property p_irq;
      s_axi_rvalid && ra_q[7:2] == 6'h0f |-> s_axi_rdata[15:0] == {8'h00, irq_line};
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt fields wrong");
   property p_unmapped;
      s_axi_rvalid && ra_q[7:2] == 6'h08 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answered wrongly");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_pf: cover property (pf_hit);
   c_io: cover property (io_hit);
endmodule // bwc_chk

bind bwc_regs bwc_chk u_chk (.*);

// ==== test/bwc_axi_master.sv ====
// Behavioural AXI4-Lite master in place of configuration software
module bwc_axi_master (
   input logic aclk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input logic wready,
   input logic [1:0] bresp,
   input logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input logic arready,
   input logic [31:0] rdata,
   input logic [1:0] rresp,
   input logic rvalid,
   output logic rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Response readies stay high so no signal is driven twice per step
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
      bready = 1'b1;
      rready = 1'b1;
   end
   task automatic xfer(input bit we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
         output logic [31:0] q, output logic [1:0] r, output bit t);
      int n;
      n = 0;
      q = 32'h0;
      if (we) begin
         awaddr <= a;
         wdata <= d;
         wstrb <= s;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
         end while (!bvalid && n < 64);
         r = bresp;
      end else begin
         araddr <= a;
         arvalid <= 1'b1;
         do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
         end while (!rvalid && n < 64);
         r = rresp;
         q = rdata;
      end
      t = (n >= 64);
   endtask
endmodule // bwc_axi_master

// ==== test/bwc_regs_tb_top.sv ====
// Self-checking bench for the window register bank
module bwc_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0;
   logic aresetn = 0;
   logic [11:0] pf_bottom_low = 12'h000;
   logic [3:0] io_bottom_low = 4'h0;
   logic [3:0] io_top_low = 4'h0;
   logic [63:0] mem_addr = 64'h0;
   logic [31:0] io_addr = 32'h0;
   wire pf_hit, io_hit, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   wire [7:0] irq_line, awaddr, araddr;
   wire [31:0] wdata, rdata;
   wire [3:0] wstrb;
   wire [1:0] bresp, rresp;
   int num_errors = 0;
   int tests_run = 0;
   initial forever #2.5 aclk = ~aclk;
   bwc_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pf_bottom_low(pf_bottom_low), .io_bottom_low(io_bottom_low),
      .io_top_low(io_top_low), .mem_addr(mem_addr), .io_addr(io_addr), .pf_hit(pf_hit),
      .io_hit(io_hit), .irq_line(irq_line));
   bwc_axi_master m (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One bus access; a hung handshake ends the run at once
   task automatic acc(input bit we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] ed,
         input logic [1:0] er);
      logic [31:0] q;
      logic [1:0] r;
      bit t;
      m.xfer(we, a, d, 4'hf, q, r, t);
      if (t) begin
         num_errors++;
         tally_and_finish();
      end else begin
         chk("resp", r, er);
         if (!we) chk("rdata", q, ed);
      end
   endtask
   task automatic hit(input logic [63:0] ma, input logic [31:0] ia, input logic ep, input logic ei);
      mem_addr <= ma;
      io_addr <= ia;
      repeat (2) @(posedge aclk);
      #1;
      chk("pf_hit", pf_hit, ep);
      chk("io_hit", io_hit, ei);
      @(posedge aclk);
   endtask
   task automatic t_reset;
      acc(0, 8'h24, 0, 32'h00010000, 0);
      acc(0, 8'h28, 0, 0, 0);
      acc(0, 8'h2c, 0, 0, 0);
      acc(0, 8'h30, 0, 0, 0);
      acc(0, 8'h34, 0, 32'h80, 0);
      acc(0, 8'h3c, 0, 0, 0);
      $display("Test reset values done");
   endtask
   task automatic t_regs;
      acc(1, 8'h24, 32'hffffffff, 0, 0);
      acc(0, 8'h24, 0, 32'hfff10000, 0);
      acc(1, 8'h28, 32'h12345678, 0, 0);
      acc(0, 8'h28, 0, 32'h12345678, 0);
      acc(1, 8'h2c, 32'h9abcdef0, 0, 0);
      acc(0, 8'h2c, 0, 32'h9abcdef0, 0);
      acc(1, 8'h30, 32'h5555aaaa, 0, 0);
      acc(0, 8'h30, 0, 32'h5555aaaa, 0);
      acc(1, 8'h34, 32'h0, 0, 0);
      acc(0, 8'h34, 0, 32'h80, 0);
      acc(1, 8'h3c, 32'hffffffff, 0, 0);
      acc(0, 8'h3c, 0, 32'hff, 0);
      chk("irq_line", irq_line, 8'hff);
      // Offset below the bank must be refused both ways
      acc(1, 8'h20, 32'hffffffff, 0, 2'b10);
      acc(0, 8'h20, 0, 0, 2'b10);
      $display("Test register access done");
   endtask
   task automatic t_win;
      pf_bottom_low <= 12'h100;
      io_bottom_low <= 4'h8;
      io_top_low <= 4'h3;
      acc(1, 8'h28, 32'h1, 0, 0);
      acc(1, 8'h2c, 32'h1, 0, 0);
      acc(1, 8'h24, 32'h20000000, 0, 0);
      acc(1, 8'h30, 32'h00020001, 0, 0);
      hit(64'h1_0fff_ffff, 32'h0001_7fff, 0, 0);
      hit(64'h1_1000_0000, 32'h0001_8000, 1, 1);
      hit(64'h1_200f_ffff, 32'h0002_3fff, 1, 1);
      hit(64'h1_2010_0000, 32'h0002_4000, 0, 0);
      hit(64'h0_1500_0000, 32'h0003_0000, 0, 0);
      $display("Test window decode done");
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_regs();
      t_win();
      tally_and_finish();
   end
endmodule // bwc_regs_tb_top
